// ===== dpsc_top.sv
// power state control: axi4-lite register file and clock gate outputs
`default_nettype none
module dpsc_top
    import dpsc_pkg::*;
(
    input  wire logic        aclk,           // clock, 10 mhz
    input  wire logic        aresetn,        // sync reset, low
    input  wire logic [15:0] s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // write strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [15:0] s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read valid
    input  wire logic        s_axi_rready,   // read ready
    input  wire logic [1:0]  hsync_raw,      // raw hsync per path
    input  wire logic [1:0]  vsync_raw,      // raw vsync per path
    output logic [6:0]       mem_clk_en,     // memory clock enable per block
    output logic [3:0]       disp_clk_en,    // display clock enable per block
    output logic [1:0]       hsync,          // gated hsync per path
    output logic [1:0]       vsync,          // gated vsync per path
    output logic [1:0]       dac_pwr_en,     // dac power per path
    output logic [1:0]       video_en        // video enable per path
);
    logic [7:0] mem_gate;
    logic [7:0] disp_gate;
    logic [7:0] sync_ctrl [2];
    logic [7:0] vid_ctrl  [2];
    logic       aw_held;
    logic       w_held;
    logic [15:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  hs_meta, hs_sync, vs_meta, vs_sync;
    dpsc_state_e pwr_state;

    // printed offsets are not all word aligned: byte address is 4x index
    function automatic logic [15:0] idx_of(input logic [15:0] a);
        idx_of = {2'h0, a[15:2]};
    endfunction : idx_of
    function automatic logic [2:0] sel_of(input logic [15:0] a);
        logic [15:0] i;
        i = idx_of(a);
        if (a[1:0] != 2'h0)          sel_of = 3'h7;
        else if (i == OFS_MEM_GATE)  sel_of = 3'h0;
        else if (i == OFS_DISP_GATE) sel_of = 3'h1;
        else if (i == OFS_SYNC_0)    sel_of = 3'h2;
        else if (i == OFS_SYNC_1)    sel_of = 3'h3;
        else if (i == OFS_VID_0)     sel_of = 3'h4;
        else if (i == OFS_VID_1)     sel_of = 3'h5;
        else if (i == OFS_STATE)     sel_of = 3'h6;
        else                         sel_of = 3'h7;
    endfunction : sel_of

    wire [15:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire aw_ok = aw_held | s_axi_awvalid;
    wire w_ok  = w_held | s_axi_wvalid;
    wire do_wr = aw_ok & w_ok & ~s_axi_bvalid;
    wire [2:0] wsel = sel_of(wr_addr);
    wire wr_lane0 = do_wr & wr_strb[0];
    wire wr_ok = (wsel != 3'h7) & (wsel != 3'h6);

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 16'h0000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (do_wr) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // no write ordering is enforced; order of gate writes is software's
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_gate  <= RST_GATE;
            disp_gate <= RST_GATE;
        end else if (wr_lane0) begin
            if (wsel == 3'h0) mem_gate  <= wr_data[7:0];
            if (wsel == 3'h1) disp_gate <= wr_data[7:0];
        end
    end

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_path
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync_ctrl[p] <= RST_SYNC;
                    vid_ctrl[p]  <= RST_VID;
                end else if (wr_lane0) begin
                    if (wsel == 3'(2 + p)) sync_ctrl[p] <= wr_data[7:0];
                    if (wsel == 3'(4 + p)) vid_ctrl[p]  <= wr_data[7:0];
                end
            end
            dpsc_path u_path (
                .aclk       (aclk),
                .aresetn    (aresetn),
                .sync_ctrl  (sync_ctrl[p]),
                .vid_ctrl   (vid_ctrl[p]),
                .hsync_in   (hs_sync[p]),
                .vsync_in   (vs_sync[p]),
                .hsync_out  (hsync[p]),
                .vsync_out  (vsync[p]),
                .dac_pwr_en (dac_pwr_en[p]),
                .video_en   (video_en[p])
            );
        end
    endgenerate

    // sync inputs come from pins: two flops before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_meta <= 2'h0;
            hs_sync <= 2'h0;
            vs_meta <= 2'h0;
            vs_sync <= 2'h0;
        end else begin
            hs_meta <= hsync_raw;
            hs_sync <= hs_meta;
            vs_meta <= vsync_raw;
            vs_sync <= vs_meta;
        end
    end

    // each bit gates its own block; a one stops that block's clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_clk_en  <= 7'h7f;
            disp_clk_en <= 4'hf;
        end else begin
            mem_clk_en  <= ~mem_gate[MEM_GATE_W-1:0];
            disp_clk_en <= ~disp_gate[DISP_GATE_W-1:0];
        end
    end

    // state as seen from the current settings, read-only status
    wire all_mem_off  = &mem_gate[MEM_GATE_W-1:0];
    wire all_disp_off = &disp_gate[DISP_GATE_W-1:0];
    wire hs_off = sync_ctrl[0][HS_LSB +: 2] != SYNC_RUN;
    wire vs_off = sync_ctrl[0][VS_LSB +: 2] != SYNC_RUN;
    wire [1:0] state_code = all_mem_off            ? 2'(DPSC_OFF) :
                            (vs_off & all_disp_off) ? 2'(DPSC_SUSPEND) :
                            (hs_off & all_disp_off) ? 2'(DPSC_STANDBY) :
                                                      2'(DPSC_ON);
    always_ff @(posedge aclk) begin
        if (!aresetn) pwr_state <= DPSC_ON;
        else          pwr_state <= dpsc_state_e'(state_code);
    end

    wire [2:0] rsel = sel_of(s_axi_araddr);
    wire [7:0] rd_byte = (rsel == 3'h0) ? mem_gate :
                         (rsel == 3'h1) ? disp_gate :
                         (rsel == 3'h2) ? sync_ctrl[0] :
                         (rsel == 3'h3) ? sync_ctrl[1] :
                         (rsel == 3'h4) ? vid_ctrl[0] :
                         (rsel == 3'h5) ? vid_ctrl[1] :
                         (rsel == 3'h6) ? {6'h00, pwr_state} : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= (rsel == 3'h7) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_mem_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && wsel == 3'h0 |=> ##1 mem_clk_en == ~$past(wr_data[6:0], 2))
        else $error("memory clock enable wrong after write");
    a_disp_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        &disp_gate[3:0] |=> disp_clk_en == 4'h0)
        else $error("display clock not stopped");
    a_disp_run: assert property (@(posedge aclk) disable iff (!aresetn)
        disp_gate[3:0] == 4'h0 |=> disp_clk_en == 4'hf)
        else $error("display clock not enabled");
    a_gate_reset: assert property (@(posedge aclk)
        !aresetn |=> mem_gate == 8'h00 && disp_gate == 8'h00)
        else $error("gate fields not cleared by reset");
    a_dac_down: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_ctrl[0][7] |=> !dac_pwr_en[0])
        else $error("dac not powered down");
    a_dac_up: assert property (@(posedge aclk) disable iff (!aresetn)
        !sync_ctrl[1][7] |=> dac_pwr_en[1])
        else $error("dac not powered");
    a_video_blank: assert property (@(posedge aclk) disable iff (!aresetn)
        vid_ctrl[0] == 8'h00 |=> !video_en[0])
        else $error("video not blanked");
    a_video_on: assert property (@(posedge aclk) disable iff (!aresetn)
        vid_ctrl[1] != 8'h00 |=> video_en[1])
        else $error("video not restored");
    a_hs_high: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_ctrl[0][1:0] == SYNC_HIGH |=> hsync[0])
        else $error("hsync not held high");
    a_off_state: assert property (@(posedge aclk) disable iff (!aresetn)
        &mem_gate[6:0] |=> pwr_state == DPSC_OFF)
        else $error("off state not reported");
    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");

    c_write: cover property (@(posedge aclk) disable iff (!aresetn)
        do_wr && wsel == 3'h1);
    c_read: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rsel == 3'h6);
    c_standby: cover property (@(posedge aclk) disable iff (!aresetn)
        pwr_state == DPSC_STANDBY);
    c_off: cover property (@(posedge aclk) disable iff (!aresetn)
        pwr_state == DPSC_OFF);
endmodule : dpsc_top
`default_nettype wire

// ===== dpsc_pkg.sv
// package: register map, field layout and reset values for power state control
// Summary of operation
// - four power states on standby suspend off
// - each block clock gated independently
// - memory gate field zero enables memory clock
// - display gate field all ones stops clock
// - display gate field zero enables display clock
// - hsync field zero lets hsync pulses run
// - hsync codes one/two hold low/high level
// - vsync field zero lets vsync pulses run
// - dac bit zero keeps video dac powered
// - dac bit one powers video dac down
// - nonzero video field restores video output
// - zero video field blanks video output
`default_nettype none
package dpsc_pkg;
    localparam logic [15:0] OFS_MEM_GATE  = 16'h00d4;
    localparam logic [15:0] OFS_DISP_GATE = 16'h00d8;
    localparam logic [15:0] OFS_VID_0     = 16'h0d30;
    localparam logic [15:0] OFS_SYNC_0    = 16'h0df7;
    localparam logic [15:0] OFS_VID_1     = 16'h1d30;
    localparam logic [15:0] OFS_SYNC_1    = 16'h1df7;
    localparam logic [15:0] OFS_STATE     = 16'h0e00;
    localparam int MEM_GATE_W  = 7;
    localparam int DISP_GATE_W = 4;
    localparam int HS_LSB  = 0;
    localparam int VS_LSB  = 2;
    localparam int DAC_BIT = 7;
    localparam logic [7:0] RST_GATE = 8'h00;
    localparam logic [7:0] RST_SYNC = 8'h00;
    localparam logic [7:0] RST_VID  = 8'h00;
    localparam logic [1:0] SYNC_RUN  = 2'h0;
    localparam logic [1:0] SYNC_LOW  = 2'h1;
    localparam logic [1:0] SYNC_HIGH = 2'h2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        DPSC_ON      = 2'b00,
        DPSC_STANDBY = 2'b01,
        DPSC_SUSPEND = 2'b10,
        DPSC_OFF     = 2'b11
    } dpsc_state_e;
endpackage : dpsc_pkg
`default_nettype wire

// ===== dpsc_path.sv
// one display path: sync hold, dac power and blanking
`default_nettype none
module dpsc_path
    import dpsc_pkg::*;
(
    input  wire logic       aclk,       // clock
    input  wire logic       aresetn,    // sync reset, low
    input  wire logic [7:0] sync_ctrl,  // sync and dac field
    input  wire logic [7:0] vid_ctrl,   // video output field
    input  wire logic       hsync_in,   // raw hsync from timing
    input  wire logic       vsync_in,   // raw vsync from timing
    output logic            hsync_out,  // gated hsync
    output logic            vsync_out,  // gated vsync
    output logic            dac_pwr_en, // dac powered
    output logic            video_en    // video not blanked
);
    wire [1:0] hs_code = sync_ctrl[HS_LSB +: 2];
    wire [1:0] vs_code = sync_ctrl[VS_LSB +: 2];
    wire next_hs = (hs_code == SYNC_RUN) ? hsync_in :
                   (hs_code == SYNC_HIGH);
    wire next_vs = (vs_code == SYNC_RUN) ? vsync_in :
                   (vs_code == SYNC_HIGH);
    // code 3 is undefined; treated as a steady low level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hsync_out  <= 1'b0;
            vsync_out  <= 1'b0;
            dac_pwr_en <= 1'b0;
            video_en   <= 1'b0;
        end else begin
            hsync_out  <= next_hs;
            vsync_out  <= next_vs;
            dac_pwr_en <= ~sync_ctrl[DAC_BIT];
            video_en   <= (vid_ctrl != 8'h00);
        end
    end
    a_hs_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        hs_code == SYNC_LOW |=> !hsync_out)
        else $error("hsync not held low");
    a_vs_run: assert property (@(posedge aclk) disable iff (!aresetn)
        vs_code == SYNC_RUN |=> vsync_out == $past(vsync_in))
        else $error("vsync not passed through");
endmodule : dpsc_path
`default_nettype wire

// ===== tb_dpsc_top.sv
// self-checking testbench for the power state control block
`default_nettype none
module tb_dpsc_top
    import dpsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] A_MEM = {OFS_MEM_GATE[13:0], 2'b00};
    localparam logic [15:0] A_DSP = {OFS_DISP_GATE[13:0], 2'b00};
    localparam logic [15:0] A_ST  = {OFS_STATE[13:0], 2'b00};
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, disp_clk_en;
    logic [1:0]  bresp, rresp, hsync_raw, vsync_raw, hsync, vsync;
    logic [1:0]  dac_pwr_en, video_en;
    logic [6:0]  mem_clk_en, v;
    logic [15:0] a_sync [2] = '{{OFS_SYNC_0[13:0], 2'b00},
                                {OFS_SYNC_1[13:0], 2'b00}};
    logic [15:0] a_vid  [2] = '{{OFS_VID_0[13:0], 2'b00},
                                {OFS_VID_1[13:0], 2'b00}};
    logic [7:0]  st_mem [4] = '{8'h00, 8'h00, 8'h00, 8'h7f};
    logic [7:0]  st_dsp [4] = '{8'h00, 8'h0f, 8'h0f, 8'h0f};
    logic [7:0]  st_syn [4] = '{8'h00, 8'h81, 8'h84, 8'h8a};
    logic [7:0]  st_vid [4] = '{8'h5a, 8'h00, 8'h00, 8'h00};
    logic [1:0]  bq [$];
    logic [33:0] rq [$];
    int          num_errors, check_count, cycles, seed, s;

    dpsc_top dpsc_top_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .hsync_raw(hsync_raw), .vsync_raw(vsync_raw),
        .mem_clk_en(mem_clk_en), .disp_clk_en(disp_clk_en), .hsync(hsync),
        .vsync(vsync), .dac_pwr_en(dac_pwr_en), .video_en(video_en));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [33:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // a hang in any handshake ends here
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready)
            check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
        if (rvalid === 1'b1 && rready)
            check("rdata", {rresp, rdata}, rq.pop_front());
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic [1:0] er = RESP_OKAY, input logic s0 = 1'b1);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'($urandom()), d};
        wstrb   <= {3'($urandom()), s0};
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        bq.push_back(er);
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (!w_ok && wready) begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] ed,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        rq.push_back({er, 24'h0, ed});
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd

    // register lands on the same edge as the response, the output one edge later
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask : settle

    // random raw sync must not leak through a held field
    task automatic hold_chk(input int p, input logic eh, ev);
        repeat (6) begin
            @(posedge aclk);
            hsync_raw <= 2'($urandom());
            vsync_raw <= 2'($urandom());
            #1;
            check("hsync held", 34'(hsync[p]), 34'(eh));
            check("vsync held", 34'(vsync[p]), 34'(ev));
        end
    endtask : hold_chk

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, hsync_raw, vsync_raw} = '0;
        seed = $urandom(32'h5c9d18f7);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        check("mem_clk_en", 34'(mem_clk_en), 34'h7f);
        check("disp_clk_en", 34'(disp_clk_en), 34'hf);
        foreach (a_sync[p]) begin
            rd(a_sync[p], RST_SYNC);
            rd(a_vid[p], RST_VID);
        end
        rd(A_MEM, RST_GATE);
        rd(A_DSP, RST_GATE);
        rd(16'h0100, 8'h00, RESP_SLVERR);
        wr(16'h0100, 8'hff, RESP_SLVERR);
        wr(A_MEM + 16'h2, 8'hff, RESP_SLVERR);
        wr(A_ST, 8'h03, RESP_SLVERR);
        rd(A_ST, 8'h00);
        rd(A_MEM, 8'h00);
        repeat (4) begin
            v = 7'($urandom());
            wr(A_MEM, {1'b0, v});
            settle();
            check("mem_clk_en", 34'(mem_clk_en), 34'(7'(~v)));
            rd(A_MEM, {1'b0, v});
            wr(A_DSP, {4'h0, v[3:0]});
            settle();
            check("disp_clk_en", 34'(disp_clk_en), 34'(4'(~v[3:0])));
        end
        wr(A_MEM, 8'h00);
        wr(A_DSP, 8'h0f);
        settle();
        check("mem_clk_en", 34'(mem_clk_en), 34'h7f);
        check("disp_clk_en", 34'(disp_clk_en), 34'h0);
        wr(A_DSP, 8'h00);
        wr(A_MEM, 8'h7f, RESP_OKAY, 1'b0);
        settle();
        check("disp_clk_en", 34'(disp_clk_en), 34'hf);
        check("mem_clk_en", 34'(mem_clk_en), 34'h7f);
        // path 1 and its scaler off, path 0 left running
        wr(A_DSP, 8'h06);
        settle();
        check("disp_clk_en", 34'(disp_clk_en), 34'h9);
        wr(A_DSP, 8'h00);
        for (int p = 0; p < 2; p++) begin
            for (int c = 1; c < 4; c++) begin
                // the other field is held low so random raw sync stays out
                wr(a_sync[p], 8'(c) | 8'h04);
                hold_chk(p, c == 2, 1'b0);
                wr(a_sync[p], 8'(c << VS_LSB) | 8'h01);
                hold_chk(p, 1'b0, c == 2);
            end
            wr(a_sync[p], {SYNC_HIGH, SYNC_LOW});
            hold_chk(p, 1'b0, 1'b1);
            wr(a_sync[p], 8'h00);
            for (int b = 0; b < 2; b++) begin
                @(posedge aclk);
                hsync_raw[p] <= b[0];
                vsync_raw[p] <= ~b[0];
                repeat (6) @(posedge aclk);
                #1;
                check("hsync pass", 34'(hsync[p]), 34'(b[0]));
                check("vsync pass", 34'(vsync[p]), 34'(1'(~b[0])));
            end
            check("dac on", 34'(dac_pwr_en[p]), 34'h1);
            wr(a_sync[p], 8'h80);
            settle();
            check("dac off", 34'(dac_pwr_en[p]), 34'h0);
            v = 7'($urandom_range(126, 0));
            wr(a_vid[p], {1'b0, v} + 8'h1);
            settle();
            check("video on", 34'(video_en[p]), 34'h1);
            rd(a_vid[p], {1'b0, v} + 8'h1);
            wr(a_vid[p], 8'h00);
            settle();
            check("video blank", 34'(video_en[p]), 34'h0);
        end
        // standby, suspend, off, then back on; each set is absolute
        for (int i = 1; i < 5; i++) begin
            s = i % 4;
            if (s == 0)
                wr(A_DSP, st_dsp[s]);
            wr(A_MEM, st_mem[s]);
            foreach (a_sync[p]) begin
                wr(a_sync[p], st_syn[s]);
                wr(a_vid[p], st_vid[s]);
            end
            if (s != 0)
                wr(A_DSP, st_dsp[s]);
            settle();
            rd(A_ST, 8'(s));
            check("state dac", 34'(dac_pwr_en), s == 0 ? 34'h3 : 34'h0);
            check("state video", 34'(video_en), s == 0 ? 34'h3 : 34'h0);
            check("state disp", 34'(disp_clk_en),
                  34'(4'(~st_dsp[s][3:0])));
            check("state mem", 34'(mem_clk_en),
                  34'(7'(~st_mem[s][6:0])));
        end
        give_verdict();
    end
endmodule : tb_dpsc_top
`default_nettype wire
